// ===== rtl/t2cfg_top.sv
// register file, mode decode, source selection and pin routing of timer 2
`timescale 1ns/1ps
module t2cfg_top
    import t2cfg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // counting datapath
    input wire logic ovf_i,
    input wire logic low_ovf_i,
    input wire logic cnt_load_i,
    input wire logic [15:0] cnt_val_i,
    input wire logic clk_out_level_i,
    // same-clock events
    input wire logic baud_gen_overflow_i,
    input wire logic ext_irq0_event_i,
    input wire logic ext_irq1_event_i,
    input wire logic timer0_overflow_i,
    input wire logic comparator_event_i,
    input wire logic keypad_event_i,
    // asynchronous inputs
    input wire logic [5:0] pins_i,
    input wire logic serial_receive_line_i,
    input wire logic slow_internal_osc_i,
    input wire logic comparator_output_i,
    input wire logic two_wire_clock_line_i,
    // configuration and datapath outputs
    output t2cfg_cfg_s cfg_o,
    output logic [15:0] count_o,
    output logic [15:0] reload_o,
    output logic count_wr_o,
    output logic timer_tick_o,
    output logic low_tick_o,
    output logic capture_level_o,
    // pins and interrupts
    output logic [5:0] pins_o,
    output logic [5:0] pins_oe_o,
    output logic timer_irq_o,
    output logic irq_o
);

    // index of the timer pin (trig=0) or the external trigger pin (trig=1)
    function automatic logic [2:0] route_pin(input logic [1:0] sel, input logic trig);
        logic [2:0] idx;
        idx = 3'h0;
        case (sel)
            2'h0: idx = trig ? 3'(PIN_P30) : 3'(PIN_P31);
            2'h1: idx = trig ? 3'(PIN_P46) : 3'(PIN_P33);
            2'h2: idx = trig ? 3'(PIN_P33) : 3'(PIN_P46);
            default: idx = trig ? 3'(PIN_P44) : 3'(PIN_P45);
        endcase
        return idx;
    endfunction : route_pin

    logic [7:0] ctrl_q;
    logic [7:0] mode_q;
    logic [7:0] mext_q;
    logic [7:0] route_q;
    logic rclk_q;
    logic serial_tx_clock_sel_q;
    logic low_flag_q;
    logic low_ie_q;
    logic low_speed_q;
    logic invert_q;
    logic [15:0] reload_q;
    logic [15:0] count_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_en_q;
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic [9:0] prev_q;
    logic [3:0] pre_q;
    logic pre_tick_q;

    // register access decode
    wire wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);
    wire wr_mode = reg_wr_i && (reg_addr_i == ADDR_MODE);
    wire wr_mext = reg_wr_i && (reg_addr_i == ADDR_MODE_EXT);
    wire wr_route = reg_wr_i && (reg_addr_i == ADDR_PIN_ROUTE);
    wire wr_rl_lo = reg_wr_i && (reg_addr_i == ADDR_RELOAD_LO);
    wire wr_rl_hi = reg_wr_i && (reg_addr_i == ADDR_RELOAD_HI);
    wire wr_cnt_lo = reg_wr_i && (reg_addr_i == ADDR_COUNT_LO);
    wire wr_cnt_hi = reg_wr_i && (reg_addr_i == ADDR_COUNT_HI);
    wire wr_iclr = reg_wr_i && (reg_addr_i == ADDR_IRQ_CLEAR);
    wire wr_ien = reg_wr_i && (reg_addr_i == ADDR_IRQ_ENABLE);
    wire alt_sel = mext_q[MEXT_ALT_SEL];
    wire split = mode_q[MODE_SPLIT];

    // mode decode
    wire [2:0] mode_code = {mext_q[MEXT_MODE_HI], ctrl_q[CTRL_MODE_MID], mode_q[MODE_MODE_LO]};
    t2cfg_mode_e mode_dec;
    always_comb
    begin
        case (mode_code)
            3'h0: mode_dec = MODE_RELOAD_EXT;
            3'h1: mode_dec = MODE_RELOAD_EXT_ALT;
            3'h2: mode_dec = MODE_CAPTURE;
            3'h3: mode_dec = MODE_CAPTURE_ZERO;
            3'h4: mode_dec = split ? MODE_PWM8 : MODE_RESERVED;
            3'h6: mode_dec = split ? MODE_RESERVED : MODE_DUTY;
            default: mode_dec = MODE_RESERVED;
        endcase
    end

    // source selectors
    wire [2:0] clk_sel = {mext_q[MEXT_CLK_MSB], mode_q[MODE_SPEED], ctrl_q[CTRL_CT]};
    wire [1:0] low_sel = {mext_q[MEXT_LOW_CLK], low_speed_q};
    wire [2:0] cap_sel = mext_q[MEXT_CAP_SEL +: 3];
    wire [1:0] route_sel = route_q[ROUTE_SEL +: 2];
    wire [2:0] t2_idx = route_pin(route_sel, 1'b0);
    wire [2:0] trig_idx = route_pin(route_sel, 1'b1);
    wire t2_fall = prev_q[t2_idx] && !sync2_q[t2_idx];
    // the access select only picks which bit software sees; the invert keeps acting while hidden
    wire trig_level = sync2_q[trig_idx] ^ invert_q;

    logic tick_d;
    always_comb
    begin
        case (clk_sel)
            3'h0: tick_d = pre_tick_q;
            3'h1: tick_d = t2_fall;
            3'h2: tick_d = 1'b1;
            3'h3: tick_d = split ? low_ovf_i : ext_irq0_event_i;
            3'h4: tick_d = baud_gen_overflow_i;
            3'h5: tick_d = timer0_overflow_i;
            3'h6: tick_d = comparator_event_i;
            default: tick_d = keypad_event_i;
        endcase
    end

    logic low_tick_d;
    always_comb
    begin
        case (low_sel)
            2'h0: low_tick_d = pre_tick_q;
            2'h1: low_tick_d = 1'b1;
            2'h2: low_tick_d = baud_gen_overflow_i;
            default: low_tick_d = ext_irq0_event_i;
        endcase
    end

    logic cap_d;
    always_comb
    begin
        case (cap_sel)
            3'h0: cap_d = trig_level;
            3'h1: cap_d = sync2_q[AS_RX];
            3'h2: cap_d = sync2_q[PIN_P45];
            3'h3: cap_d = ext_irq1_event_i;
            3'h4: cap_d = sync2_q[AS_OSC];
            3'h5: cap_d = sync2_q[AS_CMP];
            3'h6: cap_d = keypad_event_i;
            default: cap_d = sync2_q[AS_SCL];
        endcase
    end

    // flag updates; a hardware set wins over a software write
    wire ovf_set = ovf_i && !rclk_q && !serial_tx_clock_sel_q;
    wire low_set = low_ovf_i && split;
    wire ovf_d = ovf_set || (wr_ctrl ? reg_wdata_i[CTRL_OVF] : ctrl_q[CTRL_OVF]);
    wire low_flag_d = low_set || ((wr_ctrl && alt_sel) ? reg_wdata_i[CTRL_ALT5] : low_flag_q);
    wire [2:0] irq_ev = {wr_mext && (mode_dec == MODE_RESERVED), low_set, ovf_set};
    wire [2:0] irq_stat_d = irq_ev | (irq_stat_q & ~(wr_iclr ? reg_wdata_i[2:0] : 3'h0));
    wire timer_irq_d = (ctrl_q[CTRL_OVF] && !mext_q[MEXT_IGNORE]) || ctrl_q[CTRL_EXT]
        || (low_flag_q && low_ie_q);

    // readback mux
    wire [7:0] ctrl_rd = {ctrl_q[7:6], alt_sel ? {low_flag_q, low_ie_q} : {rclk_q, serial_tx_clock_sel_q}, ctrl_q[3:0]};
    wire [7:0] mode_rd = {mode_q[7], alt_sel ? invert_q : low_speed_q, mode_q[5:0]};
    logic [7:0] rd_mux;
    always_comb
    begin
        case (reg_addr_i)
            ADDR_CTRL: rd_mux = ctrl_rd;
            ADDR_MODE: rd_mux = mode_rd;
            ADDR_MODE_EXT: rd_mux = mext_q;
            ADDR_PIN_ROUTE: rd_mux = route_q;
            ADDR_RELOAD_LO: rd_mux = reload_q[7:0];
            ADDR_RELOAD_HI: rd_mux = reload_q[15:8];
            ADDR_COUNT_LO: rd_mux = count_q[7:0];
            ADDR_COUNT_HI: rd_mux = count_q[15:8];
            ADDR_IRQ_STATUS: rd_mux = {5'h00, irq_stat_q};
            ADDR_IRQ_ENABLE: rd_mux = {5'h00, irq_en_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // count: a software byte write wins over a datapath load of that byte
    wire [7:0] cnt_lo_d = wr_cnt_lo ? reg_wdata_i : (cnt_load_i ? cnt_val_i[7:0] : count_q[7:0]);
    wire [7:0] cnt_hi_d = wr_cnt_hi ? reg_wdata_i : (cnt_load_i ? cnt_val_i[15:8] : count_q[15:8]);

    // clock output drives the routed timer pin
    wire [5:0] oe_d = mode_q[MODE_CLKOUT] ? (6'h01 << t2_idx) : 6'h00;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
            prev_q <= 10'h000;
        end
        else
        begin
            sync1_q <= {two_wire_clock_line_i, comparator_output_i, slow_internal_osc_i,
                serial_receive_line_i, pins_i};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pre_q <= 4'h0;
            pre_tick_q <= 1'b0;
        end
        else
        begin
            pre_q <= (pre_q == 4'(PRESCALE_DIV - 1)) ? 4'h0 : pre_q + 4'h1;
            pre_tick_q <= (pre_q == 4'(PRESCALE_DIV - 1));
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_q <= RST_CTRL;
            mode_q <= RST_MODE;
            mext_q <= RST_MODE_EXT;
            route_q <= RST_PIN_ROUTE;
        end
        else
        begin
            ctrl_q <= wr_ctrl ? {ovf_d, reg_wdata_i[6:0]} : {ovf_d, ctrl_q[6:0]};
            if (wr_mode)
                mode_q <= reg_wdata_i;
            if (wr_mext)
                mext_q <= reg_wdata_i;
            if (wr_route)
                route_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            {rclk_q, serial_tx_clock_sel_q, low_flag_q, low_ie_q, low_speed_q, invert_q} <= 6'h00;
        end
        else
        begin
            low_flag_q <= low_flag_d;
            if (wr_ctrl && !alt_sel)
                {rclk_q, serial_tx_clock_sel_q} <= reg_wdata_i[CTRL_ALT5 -: 2];
            if (wr_ctrl && alt_sel)
                low_ie_q <= reg_wdata_i[CTRL_ALT4];
            if (wr_mode && !alt_sel)
                low_speed_q <= reg_wdata_i[MODE_ALT6];
            if (wr_mode && alt_sel)
                invert_q <= reg_wdata_i[MODE_ALT6];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reload_q <= RST_RELOAD;
            count_q <= RST_COUNT;
        end
        else
        begin
            if (wr_rl_lo)
                reload_q[7:0] <= reg_wdata_i;
            if (wr_rl_hi)
                reload_q[15:8] <= reg_wdata_i;
            count_q <= {cnt_hi_d, cnt_lo_d};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_stat_q <= RST_IRQ;
            irq_en_q <= RST_IRQ;
            irq_o <= 1'b0;
            timer_irq_o <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            if (wr_ien)
                irq_en_q <= reg_wdata_i[2:0];
            irq_o <= |(irq_stat_q & irq_en_q);
            timer_irq_o <= timer_irq_d;
        end
    end

    // outputs follow the registers one cycle later, count untouched
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_o <= '{MODE_RELOAD_EXT, 1'b0, 3'h0, 2'h0, 3'h0, 2'h0, 1'b0};
            reg_rdata_o <= 8'h00;
            count_o <= RST_COUNT;
            reload_o <= RST_RELOAD;
            count_wr_o <= 1'b0;
            timer_tick_o <= 1'b0;
            low_tick_o <= 1'b0;
            capture_level_o <= 1'b0;
            pins_o <= 6'h00;
            pins_oe_o <= 6'h00;
        end
        else
        begin
            cfg_o <= '{mode_dec, split, clk_sel, low_sel, cap_sel, route_sel, mode_q[MODE_CLKOUT]};
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
            count_o <= count_q;
            reload_o <= reload_q;
            count_wr_o <= wr_cnt_lo || wr_cnt_hi;
            timer_tick_o <= tick_d;
            low_tick_o <= split && low_tick_d;
            capture_level_o <= cap_d;
            pins_o <= clk_out_level_i ? oe_d : 6'h00;
            pins_oe_o <= oe_d;
        end
    end

    sequence s_wr_cnt_lo;
        reg_wr_i && (reg_addr_i == ADDR_COUNT_LO);
    endsequence
    sequence s_wr_mext_idle;
        reg_wr_i && (reg_addr_i == ADDR_MODE_EXT) && !cnt_load_i;
    endsequence

    property p_mode_capture;
        @(posedge clk_i) disable iff (!resetn_i)
        (mode_code == 3'h2) |=> (cfg_o.mode == MODE_CAPTURE);
    endproperty
    a_mode_capture: assert property (p_mode_capture) else $error("capture code not decoded");
    property p_pwm_split;
        @(posedge clk_i) disable iff (!resetn_i)
        (cfg_o.mode == MODE_PWM8) |-> cfg_o.split;
    endproperty
    a_pwm_split: assert property (p_pwm_split) else $error("pwm mode without split");
    property p_ignore;
        @(posedge clk_i) disable iff (!resetn_i)
        (mext_q[MEXT_IGNORE] && !ctrl_q[CTRL_EXT] && !(low_flag_q && low_ie_q)) |=> !timer_irq_o;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored overflow raised interrupt");
    property p_alt0_write;
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_ctrl && !alt_sel) |=> (rclk_q == $past(reg_wdata_i[CTRL_ALT5])) && $stable(low_ie_q);
    endproperty
    a_alt0_write: assert property (p_alt0_write) else $error("serial clock select not written");
    property p_alt1_write;
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_mode && alt_sel) |=> (invert_q == $past(reg_wdata_i[MODE_ALT6])) && $stable(low_speed_q);
    endproperty
    a_alt1_write: assert property (p_alt1_write) else $error("invert bit not written");
    property p_cap_rx;
        @(posedge clk_i) disable iff (!resetn_i)
        (cap_sel == 3'h1) |=> (capture_level_o == $past(sync2_q[AS_RX]));
    endproperty
    a_cap_rx: assert property (p_cap_rx) else $error("capture source not the receive line");
    property p_low_baud;
        @(posedge clk_i) disable iff (!resetn_i)
        (split && low_sel == 2'h2) |=> (low_tick_o == $past(baud_gen_overflow_i));
    endproperty
    a_low_baud: assert property (p_low_baud) else $error("low clock not baud overflow");
    property p_clk_t0;
        @(posedge clk_i) disable iff (!resetn_i)
        (mext_q[MEXT_CLK_MSB] && !mode_q[MODE_SPEED] && ctrl_q[CTRL_CT])
            |=> (timer_tick_o == $past(timer0_overflow_i));
    endproperty
    a_clk_t0: assert property (p_clk_t0) else $error("timer clock not timer0 overflow");
    property p_cnt_lo;
        @(posedge clk_i) disable iff (!resetn_i)
        s_wr_cnt_lo |=> ##1 (count_o[7:0] == $past(reg_wdata_i, 2));
    endproperty
    a_cnt_lo: assert property (p_cnt_lo) else $error("low count byte not written");
    property p_cnt_hi;
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_cnt_hi && !wr_cnt_lo) |=> (count_q[15:8] == $past(reg_wdata_i));
    endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("high count byte not written");
    property p_reload;
        @(posedge clk_i) disable iff (!resetn_i)
        wr_rl_hi |=> ##1 (reload_o[15:8] == $past(reg_wdata_i, 2));
    endproperty
    a_reload: assert property (p_reload) else $error("reload high byte not written");
    property p_route3;
        @(posedge clk_i) disable iff (!resetn_i)
        (route_sel == 2'h3 && mode_q[MODE_CLKOUT]) |=> pins_oe_o[PIN_P45];
    endproperty
    a_route3: assert property (p_route3) else $error("clock output not on routed pin");
    property p_trig_route;
        @(posedge clk_i) disable iff (!resetn_i)
        (cap_sel == 3'h0 && route_sel == 2'h3)
            |=> (capture_level_o == ($past(sync2_q[PIN_P44]) ^ $past(invert_q)));
    endproperty
    a_trig_route: assert property (p_trig_route) else $error("trigger not on routed pin");
    property p_low_sys;
        @(posedge clk_i) disable iff (!resetn_i)
        (split && low_sel == 2'h1) |=> low_tick_o;
    endproperty
    a_low_sys: assert property (p_low_sys) else $error("low clock not system clock");
    property p_clk_sys;
        @(posedge clk_i) disable iff (!resetn_i)
        (clk_sel == 3'h2) |=> timer_tick_o;
    endproperty
    a_clk_sys: assert property (p_clk_sys) else $error("timer clock not system clock");
    property p_duty_split;
        @(posedge clk_i) disable iff (!resetn_i)
        (cfg_o.mode == MODE_DUTY) |-> !cfg_o.split;
    endproperty
    a_duty_split: assert property (p_duty_split) else $error("duty capture in split mode");
    property p_cfg_keep_count;
        @(posedge clk_i) disable iff (!resetn_i)
        s_wr_mext_idle |=> $stable(count_q) ##1 (cfg_o.cap_sel == $past(reg_wdata_i[2:0], 2));
    endproperty
    a_cfg_keep_count: assert property (p_cfg_keep_count) else $error("config write disturbed count");

endmodule : t2cfg_top

// ===== rtl/t2cfg_pkg.sv
// constants, types and register map of the timer 2 mode and source select block
package t2cfg_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'hC8;
    localparam logic [7:0] ADDR_MODE = 8'hC9;
    localparam logic [7:0] ADDR_MODE_EXT = 8'h93;
    localparam logic [7:0] ADDR_PIN_ROUTE = 8'hA4;
    localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LO = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HI = 8'hCD;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hF8;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hF9;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hFA;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_MODE_EXT = 8'h00;
    localparam logic [7:0] RST_PIN_ROUTE = 8'h00;
    localparam logic [15:0] RST_RELOAD = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [2:0] RST_IRQ = 3'h0;
    // control register fields
    localparam int CTRL_OVF = 7;
    localparam int CTRL_EXT = 6;
    localparam int CTRL_ALT5 = 5;
    localparam int CTRL_ALT4 = 4;
    localparam int CTRL_CT = 1;
    localparam int CTRL_MODE_MID = 0;
    // mode register fields
    localparam int MODE_SPLIT = 7;
    localparam int MODE_ALT6 = 6;
    localparam int MODE_SPEED = 4;
    localparam int MODE_CLKOUT = 1;
    localparam int MODE_MODE_LO = 0;
    // extended mode and pin route register fields
    localparam int MEXT_LOW_CLK = 7;
    localparam int MEXT_IGNORE = 6;
    localparam int MEXT_ALT_SEL = 5;
    localparam int MEXT_CLK_MSB = 4;
    localparam int MEXT_MODE_HI = 3;
    localparam int MEXT_CAP_SEL = 0;
    localparam int ROUTE_SEL = 6;
    // interrupt status bits
    localparam int IRQ_OVF = 0;
    localparam int IRQ_LOW_OVF = 1;
    localparam int IRQ_BAD_MODE = 2;
    // synchronised input vector positions and prescaler divide ratio
    localparam int PIN_P30 = 0;
    localparam int PIN_P31 = 1;
    localparam int PIN_P33 = 2;
    localparam int PIN_P44 = 3;
    localparam int PIN_P45 = 4;
    localparam int PIN_P46 = 5;
    localparam int AS_RX = 6;
    localparam int AS_OSC = 7;
    localparam int AS_CMP = 8;
    localparam int AS_SCL = 9;
    localparam int PRESCALE_DIV = 12;
    typedef enum logic [2:0] {
        MODE_RELOAD_EXT, MODE_RELOAD_EXT_ALT, MODE_CAPTURE, MODE_CAPTURE_ZERO,
        MODE_PWM8, MODE_DUTY, MODE_RESERVED
    } t2cfg_mode_e;
    typedef struct packed {
        t2cfg_mode_e mode;
        logic split;
        logic [2:0] clk_sel;
        logic [1:0] low_clk_sel;
        logic [2:0] cap_sel;
        logic [1:0] route;
        logic clkout_en;
    } t2cfg_cfg_s;
endpackage : t2cfg_pkg

// ===== verif/t2cfg_top_tb_top.sv
// self-checking bench for the timer 2 mode and source select block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module timer2_mode_and_source_select_tb_top;
    import t2cfg_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic ovf_i = 1'b0, low_ovf_i = 1'b0, cnt_load_i = 1'b0, clk_out_level_i = 1'b0;
    logic [15:0] cnt_val_i = 16'h0000, count_o, reload_o;
    logic baud_gen_overflow_i = 1'b0, ext_irq0_event_i = 1'b0, ext_irq1_event_i = 1'b0;
    logic timer0_overflow_i = 1'b0, comparator_event_i = 1'b0, keypad_event_i = 1'b0;
    logic [5:0] pins_i = 6'h00, pins_o, pins_oe_o;
    logic serial_receive_line_i = 1'b0, slow_internal_osc_i = 1'b0;
    logic comparator_output_i = 1'b0, two_wire_clock_line_i = 1'b0;
    t2cfg_cfg_s cfg_o;
    logic count_wr_o, timer_tick_o, low_tick_o, capture_level_o, timer_irq_o, irq_o;
    logic rd_pend_q = 1'b0;
    logic [31:0] rnd = 32'hE76E, bg = 32'hE76E;
    logic [7:0] exp_q[$];
    logic [7:0] d[5];
    int n_fail = 0, samples_checked = 0;
    logic [7:0] exp_v;
    // clock output pin for each route code
    logic [5:0] oe_exp[4] = '{6'h02, 6'h04, 6'h20, 6'h10};
    logic [7:0] regs[6] = '{ADDR_MODE_EXT, ADDR_PIN_ROUTE, ADDR_RELOAD_LO, ADDR_RELOAD_HI, ADDR_COUNT_LO,
        ADDR_COUNT_HI};
    t2cfg_top dut_u (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .ovf_i, .low_ovf_i, .cnt_load_i, .cnt_val_i, .clk_out_level_i, .baud_gen_overflow_i,
        .ext_irq0_event_i, .ext_irq1_event_i, .timer0_overflow_i, .comparator_event_i, .keypad_event_i,
        .pins_i, .serial_receive_line_i, .slow_internal_osc_i, .comparator_output_i,
        .two_wire_clock_line_i, .cfg_o, .count_o, .reload_o, .count_wr_o, .timer_tick_o, .low_tick_o,
        .capture_level_o, .pins_o, .pins_oe_o, .timer_irq_o, .irq_o);
    always #12.5 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic t2cfg_mode_e exp_mode(input logic [3:0] c);
        case (c[3:1])
            3'h0: return MODE_RELOAD_EXT;
            3'h1: return MODE_RELOAD_EXT_ALT;
            3'h2: return MODE_CAPTURE;
            3'h3: return MODE_CAPTURE_ZERO;
            3'h4: return c[0] ? MODE_PWM8 : MODE_RESERVED;
            3'h6: return c[0] ? MODE_RESERVED : MODE_DUTY;
            default: return MODE_RESERVED;
        endcase
    endfunction : exp_mode
    // background traffic on the asynchronous lines and same-clock events
    always @(posedge clk_i)
    begin
        bg <= lfsr(bg);
        {pins_i, serial_receive_line_i, slow_internal_osc_i, comparator_output_i} <= bg[8:0];
        {two_wire_clock_line_i, baud_gen_overflow_i, ext_irq0_event_i} <= bg[11:9];
        {ext_irq1_event_i, timer0_overflow_i, comparator_event_i, keypad_event_i} <= bg[15:12];
        clk_out_level_i <= bg[16];
    end
    task automatic complete_run();
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        exp_q.push_back(v);
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd
    // read data stand only in the cycle after the strobe
    always @(posedge clk_i) rd_pend_q <= reg_rd_i;
    always @(negedge clk_i)
    begin
        if (rd_pend_q && exp_q.size() == 0)
        begin
            n_fail++;
            $display("Error %0t: read data with no expected value", $time);
        end
        else if (rd_pend_q)
        begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata_o, exp_v)
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        complete_run();
    end
    initial
    begin
        int k;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            rnd = lfsr(rnd);
            d[i] = rnd[7:0];
            wr(regs[i + 1], d[i]);
            @(negedge clk_i);
            `CHK(count_wr_o, i >= 3)
            rd(regs[i + 1], d[i]);
        end
        rd(8'h00, 8'h00);
        repeat (2) @(negedge clk_i);
        `CHK(reload_o, {d[2], d[1]})
        for (int i = 0; i < 16; i++)
        begin
            rnd = lfsr(rnd);
            wr(ADDR_MODE, {i[0], rnd[3], 1'b0, rnd[1], 3'h0, i[1]});
            wr(ADDR_CTRL, {6'h00, rnd[0], i[2]});
            wr(ADDR_MODE_EXT, {rnd[4], 2'h0, rnd[2], i[3], i[2:0]});
            repeat (2) @(negedge clk_i);
            `CHK(cfg_o.mode, exp_mode(i[3:0]))
            `CHK(cfg_o.split, i[0])
            `CHK(cfg_o.cap_sel, i[2:0])
            `CHK(cfg_o.clk_sel, rnd[2:0])
            `CHK(cfg_o.low_clk_sel, rnd[4:3])
        end
        `CHK(count_o, {d[4], d[3]})
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_CTRL, 8'h30);
        wr(ADDR_MODE_EXT, 8'h20);
        rd(ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, 8'h10);
        wr(ADDR_MODE, 8'h40);
        rd(ADDR_CTRL, 8'h10);
        wr(ADDR_MODE_EXT, 8'h00);
        rd(ADDR_CTRL, 8'h30);
        rd(ADDR_MODE, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_IRQ_CLEAR, 8'h07);
        @(posedge clk_i);
        ovf_i <= 1'b1;
        @(posedge clk_i);
        ovf_i <= 1'b0;
        k = 0;
        while (timer_irq_o !== 1'b1 && k < 8)
        begin
            @(negedge clk_i);
            k++;
        end
        `CHK(timer_irq_o, 1'b1)
        `CHK(irq_o, 1'b0)
        wr(ADDR_IRQ_ENABLE, 8'h01);
        repeat (2) @(negedge clk_i);
        `CHK(irq_o, 1'b1)
        rd(ADDR_IRQ_STATUS, 8'h01);
        wr(ADDR_MODE_EXT, 8'h40);
        repeat (3) @(negedge clk_i);
        `CHK(timer_irq_o, 1'b0)
        wr(ADDR_IRQ_CLEAR, 8'h01);
        repeat (2) @(negedge clk_i);
        `CHK(irq_o, 1'b0)
        rd(ADDR_IRQ_STATUS, 8'h00);
        rd(ADDR_IRQ_CLEAR, 8'h00);
        // clock output pin on every route code, with the trigger invert set but not checked
        wr(ADDR_MODE_EXT, 8'h60);
        wr(ADDR_MODE, 8'h42);
        for (int s = 0; s < 4; s++)
        begin
            wr(ADDR_PIN_ROUTE, {s[1:0], 6'h00});
            repeat (2) @(negedge clk_i);
            `CHK(cfg_o.route, s[1:0])
            `CHK(pins_oe_o, oe_exp[s])
            `CHK(pins_o & ~oe_exp[s], 6'h00)
        end
        `CHK(cfg_o.clkout_en, 1'b1)
        repeat (3) @(posedge clk_i);
        complete_run();
    end
endmodule : timer2_mode_and_source_select_tb_top
